//--- core/fces_defs.vh
`ifndef FCES_DEFS_VH
`define FCES_DEFS_VH
`define FCES_OFS_SPEED      16'h0000
`define FCES_OFS_COUNT      16'h0001
`define FCES_OFS_ADDR_HI    16'h0002
`define FCES_OFS_ADDR_LO    16'h0003
`define FCES_OFS_DATA       16'h0004
`define FCES_PAGE_MASK      16'hFFC0
`define FCES_PROTECT_ADDR   16'hFFFE
`define FCES_WDOG_BASE      16'h0048
`define FCES_WDOG_LEAD      16'h0004
`define FCES_WDOG_PERIOD    16'h0100
`define FCES_ERASE_UNITS    24'h0010
`define FCES_ERASE_MUL      24'h044C
`define FCES_SPEED_MIN      8'h06
`define FCES_SPEED_MAX      8'h20
`define FCES_BUF_DEPTH      2
`endif

//--- core/fces_skid_buf.v
`timescale 1ns/1ps
`default_nettype none
module fces_skid_buf
(
    // clock and reset
    input  wire        clk,
    input  wire        rstN,
    // fill side
    input  wire        inValid,
    input  wire [7:0]  inData,
    output wire        inReady,
    // drain side
    output wire        outValid,
    input  wire        outReady,
    output wire [7:0]  outData
);
    reg  [7:0] entry_reg [0:1];
    reg        rdPtr_reg;
    reg        wrPtr_reg;
    reg  [1:0] count_reg;
    wire       push;
    wire       pop;
    assign inReady  = (count_reg != 2'h2);
    assign outValid = (count_reg != 2'h0);
    assign outData  = entry_reg[rdPtr_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            rdPtr_reg <= 1'b0;
            wrPtr_reg <= 1'b0;
            count_reg <= 2'h0;
            entry_reg[0] <= 8'h00;
            entry_reg[1] <= 8'h00;
        end
        else
        begin
            if (push)
            begin
                entry_reg[wrPtr_reg] <= inData;
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (pop)
                rdPtr_reg <= ~rdPtr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule // fces_skid_buf
`default_nettype wire

//--- core/flash_copy_erase_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "fces_defs.vh"
module flash_copy_erase_sequencer
(
    // clock and reset
    input  wire        clk_sys,
    input  wire        reset_n,
    // request from software
    input  wire        reqCopy,
    input  wire        reqErase,
    input  wire [15:0] paramBlockBase,
    input  wire        intMaskIn,
    output wire        busy,
    output reg         done,
    output reg         eraseRefused,
    // ram port
    output reg         ramRd,
    output reg         ramWr,
    output reg  [15:0] ramAddr,
    output reg  [7:0]  ramWrData,
    input  wire [7:0]  ramRdData,
    // flash port
    output reg         flashRd,
    output reg  [15:0] flashAddr,
    input  wire [7:0]  flashRdData,
    output reg         erasePage,
    output reg         eraseMass,
    output reg  [15:0] eraseAddr,
    input  wire        protectHit,
    // system
    input  wire        testHighVoltage,
    output reg         intMaskOut,
    output reg         watchdogService
);
    localparam [10:0] S_IDLE  = 11'h001;
    localparam [10:0] S_SPEED = 11'h002;
    localparam [10:0] S_COUNT = 11'h004;
    localparam [10:0] S_AHI   = 11'h008;
    localparam [10:0] S_ALO   = 11'h010;
    localparam [10:0] S_DECID = 11'h020;
    localparam [10:0] S_FRD   = 11'h040;
    localparam [10:0] S_FCAP  = 11'h080;
    localparam [10:0] S_ERASE = 11'h100;
    localparam [10:0] S_DONE  = 11'h200;
    localparam [10:0] S_PCHK  = 11'h400;

    reg  [1:0]  rstSync_reg;
    wire        rstN;
    reg  [10:0] state_reg;
    reg         isErase_reg;
    reg  [15:0] base_reg;
    reg  [7:0]  speed_reg;
    reg  [7:0]  count_reg;
    reg  [7:0]  rdLeft_reg;
    reg  [15:0] fAddr_reg;
    reg  [15:0] wrAddr_reg;
    reg  [7:0]  wrLeft_reg;
    reg  [23:0] eraseCnt_reg;
    reg  [15:0] wdogCnt_reg;
    reg         savedMask_reg;
    reg         bufPush;
    wire        bufReady;
    wire        bufValid;
    wire [7:0]  bufData;
    wire        drain;

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rstSync_reg <= 2'b00;
        else
            rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
    assign rstN = rstSync_reg[1];

    assign busy  = (state_reg != S_IDLE);
    assign drain = bufValid && (wrLeft_reg != 8'h00);

    fces_skid_buf u_buf
    (
        .clk      (clk_sys),
        .rstN     (rstN),
        .inValid  (bufPush),
        .inData   (flashRdData),
        .inReady  (bufReady),
        .outValid (bufValid),
        .outReady (1'b1),
        .outData  (bufData)
    );

    always @*
    begin
        bufPush = (state_reg == S_FCAP);
    end

    always @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg <= S_IDLE;
            isErase_reg <= 1'b0;
            base_reg <= 16'h0000;
            speed_reg <= 8'h00;
            count_reg <= 8'h00;
            rdLeft_reg <= 8'h00;
            fAddr_reg <= 16'h0000;
            wrAddr_reg <= 16'h0000;
            wrLeft_reg <= 8'h00;
            eraseCnt_reg <= 24'h000000;
            wdogCnt_reg <= 16'h0000;
            savedMask_reg <= 1'b0;
            done <= 1'b0;
            eraseRefused <= 1'b0;
            ramRd <= 1'b0;
            ramWr <= 1'b0;
            ramAddr <= 16'h0000;
            ramWrData <= 8'h00;
            flashRd <= 1'b0;
            flashAddr <= 16'h0000;
            erasePage <= 1'b0;
            eraseMass <= 1'b0;
            eraseAddr <= 16'h0000;
            intMaskOut <= 1'b0;
            watchdogService <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            ramRd <= 1'b0;
            ramWr <= 1'b0;
            flashRd <= 1'b0;
            watchdogService <= 1'b0;
            if (state_reg == S_IDLE)
                intMaskOut <= intMaskIn;
            // drain buffer into data array in order
            if (drain)
            begin
                ramWr <= 1'b1;
                ramAddr <= wrAddr_reg;
                ramWrData <= bufData;
                wrAddr_reg <= wrAddr_reg + 16'h0001;
                wrLeft_reg <= wrLeft_reg - 8'h01;
            end
            // watchdog service during erase only
            if (isErase_reg && busy)
            begin
                if (wdogCnt_reg == 16'h0000)
                begin
                    watchdogService <= 1'b1;
                    wdogCnt_reg <= `FCES_WDOG_PERIOD;
                end
                else
                    wdogCnt_reg <= wdogCnt_reg - 16'h0001;
            end
            case (state_reg)
                S_IDLE:
                begin
                    if (reqCopy || reqErase)
                    begin
                        isErase_reg <= reqErase && !reqCopy;
                        savedMask_reg <= intMaskIn;
                        if (reqErase && !reqCopy)
                            intMaskOut <= 1'b1;
                        base_reg <= paramBlockBase;
                        // no service before the speed-based count is loaded
                        wdogCnt_reg <= `FCES_WDOG_PERIOD;
                        ramRd <= 1'b1;
                        ramAddr <= paramBlockBase + `FCES_OFS_SPEED;
                        eraseRefused <= 1'b0;
                        state_reg <= S_SPEED;
                    end
                end
                S_SPEED:
                begin
                    ramRd <= 1'b1;
                    ramAddr <= base_reg + `FCES_OFS_COUNT;
                    state_reg <= S_COUNT;
                end
                S_COUNT:
                begin
                    speed_reg <= ramRdData;
                    ramRd <= 1'b1;
                    ramAddr <= base_reg + `FCES_OFS_ADDR_HI;
                    state_reg <= S_AHI;
                end
                S_AHI:
                begin
                    count_reg <= ramRdData;
                    ramRd <= 1'b1;
                    ramAddr <= base_reg + `FCES_OFS_ADDR_LO;
                    // first service at 72 + 3*speed cycles from request
                    wdogCnt_reg <= `FCES_WDOG_BASE - `FCES_WDOG_LEAD
                        + {6'h00, speed_reg, 2'b00} - {8'h00, speed_reg};
                    state_reg <= S_ALO;
                end
                S_ALO:
                begin
                    fAddr_reg[15:8] <= ramRdData;
                    state_reg <= S_DECID;
                end
                S_DECID:
                begin
                    fAddr_reg[7:0] <= ramRdData;
                    rdLeft_reg <= count_reg;
                    wrLeft_reg <= count_reg;
                    wrAddr_reg <= base_reg + `FCES_OFS_DATA;
                    eraseAddr <= {fAddr_reg[15:8], ramRdData};
                    // 16 + 1100*speed bus cycles, 4.0..5.5 ms over 1.5..8 MHz
                    eraseCnt_reg <= `FCES_ERASE_UNITS
                        + `FCES_ERASE_MUL * {16'h0000, speed_reg};
                    if (!isErase_reg)
                        state_reg <= S_FRD;
                    else if ({fAddr_reg[15:8], ramRdData} == `FCES_PROTECT_ADDR)
                    begin
                        if (testHighVoltage)
                        begin
                            eraseMass <= 1'b1;
                            state_reg <= S_ERASE;
                        end
                        else
                        begin
                            eraseRefused <= 1'b1;
                            state_reg <= S_DONE;
                        end
                    end
                    else
                    begin
                        eraseAddr <= {fAddr_reg[15:8], ramRdData} & `FCES_PAGE_MASK;
                        state_reg <= S_PCHK;
                    end
                end
                // protect input follows the page base set one cycle before
                S_PCHK:
                begin
                    if (protectHit && !testHighVoltage)
                    begin
                        eraseRefused <= 1'b1;
                        state_reg <= S_DONE;
                    end
                    else
                    begin
                        erasePage <= 1'b1;
                        state_reg <= S_ERASE;
                    end
                end
                S_FRD:
                begin
                    if (rdLeft_reg == 8'h00)
                    begin
                        if (wrLeft_reg == 8'h00 && !bufValid)
                            state_reg <= S_DONE;
                    end
                    else if (bufReady)
                    begin
                        flashRd <= 1'b1;
                        flashAddr <= fAddr_reg;
                        fAddr_reg <= fAddr_reg + 16'h0001;
                        rdLeft_reg <= rdLeft_reg - 8'h01;
                        state_reg <= S_FCAP;
                    end
                end
                S_FCAP:
                begin
                    state_reg <= S_FRD;
                end
                S_ERASE:
                begin
                    if (eraseCnt_reg == 24'h000000)
                    begin
                        erasePage <= 1'b0;
                        eraseMass <= 1'b0;
                        state_reg <= S_DONE;
                    end
                    else
                        eraseCnt_reg <= eraseCnt_reg - 24'h000001;
                end
                S_DONE:
                begin
                    done <= 1'b1;
                    intMaskOut <= savedMask_reg;
                    isErase_reg <= 1'b0;
                    state_reg <= S_IDLE;
                end
                default:
                begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // flash_copy_erase_sequencer
`default_nettype wire

//--- sim/fces_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fces_checker
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // request and status
    input wire logic        reqCopy,
    input wire logic        reqErase,
    input wire logic        intMaskIn,
    input wire logic        busy,
    input wire logic        done,
    // memory and erase
    input wire logic        flashRd,
    input wire logic        erasePage,
    input wire logic        eraseMass,
    input wire logic [15:0] eraseAddr,
    input wire logic        protectHit,
    input wire logic        testHighVoltage,
    input wire logic        intMaskOut,
    input wire logic        watchdogService
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire erasing = erasePage | eraseMass;
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done wider than one cycle");
    AST_TAKE: assert property (!busy && (reqCopy || reqErase) |=> busy)
        else $error("request not taken in idle");
    AST_MASK_HELD: assert property (erasing |-> intMaskOut)
        else $error("mask low during erase");
    AST_MASK_BACK: assert property ($fell(erasing) |-> ##[0:3] intMaskOut == intMaskIn)
        else $error("mask not restored");
    AST_COPY_QUIET: assert property (flashRd |-> !watchdogService && !erasing)
        else $error("watchdog or erase during copy");
    AST_MASS_VOLT: assert property ($rose(eraseMass) |-> testHighVoltage)
        else $error("mass erase without test voltage");
    AST_PAGE_BASE: assert property (erasePage |-> eraseAddr[5:0] == 6'h00 && !eraseMass)
        else $error("page erase address not page base");
    AST_PROT: assert property ($rose(erasePage) |-> !protectHit || testHighVoltage)
        else $error("protected page erased");
    AST_WDOG_ERASE: assert property (watchdogService |-> erasing)
        else $error("watchdog service outside erase");
    AST_ERASE_END: assert property ($fell(erasing) |-> ##[0:2] done)
        else $error("no done after erase");
    cover property ($rose(erasePage));
    cover property ($rose(eraseMass));
    cover property (flashRd ##2 flashRd);
endmodule // fces_checker
bind flash_copy_erase_sequencer fces_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .reqCopy(reqCopy), .reqErase(reqErase), .intMaskIn(intMaskIn), .busy(busy), .done(done),
    .flashRd(flashRd), .erasePage(erasePage), .eraseMass(eraseMass), .eraseAddr(eraseAddr),
    .protectHit(protectHit), .testHighVoltage(testHighVoltage), .intMaskOut(intMaskOut),
    .watchdogService(watchdogService));
`default_nettype wire

//--- sim/fces_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
module fces_sw_model
#(
    parameter [15:0] PROT_BASE = 16'hF000
)
(
    input  wire logic        clk,
    // ram side
    input  wire logic        ramRd,
    input  wire logic        ramWr,
    input  wire logic [15:0] ramAddr,
    input  wire logic [7:0]  ramWrData,
    output var  logic [7:0]  ramRdData,
    // flash side
    input  wire logic        flashRd,
    input  wire logic [15:0] flashAddr,
    output var  logic [7:0]  flashRdData,
    input  wire logic [15:0] eraseAddr,
    output wire logic        protectHit
);
    logic [7:0] ram [0:65535];
    initial ramRdData = 8'h00;
    // ram answers one cycle after the strobe, else a changing pattern
    always @(posedge clk)
    begin
        if (ramWr)
            ram[ramAddr] <= ramWrData;
        ramRdData <= ramRd ? ram[ramAddr] : ~ramRdData;
    end
    // flash answers while the strobe stands, inverse otherwise
    assign flashRdData = flashRd ? flashAddr[7:0] ^ flashAddr[15:8]
                                 : ~(flashAddr[7:0] ^ flashAddr[15:8]);
    assign protectHit = eraseAddr >= PROT_BASE;
endmodule // fces_sw_model
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
    logic clk_sys = 1'b0, reset_n = 1'b0, reqCopy = 1'b0, reqErase = 1'b0;
    logic intMaskIn = 1'b0, testHighVoltage = 1'b0;
    logic [15:0] paramBlockBase = 16'h0000, ea;
    wire logic busy, done, eraseRefused, ramRd, ramWr, flashRd, erasePage, eraseMass;
    wire logic protectHit, intMaskOut, watchdogService;
    wire logic [15:0] ramAddr, flashAddr, eraseAddr;
    wire logic [7:0] ramWrData, ramRdData, flashRdData;
    int n_mismatch = 0, tests_run = 0, cyc = 0, tWd, nPage, nMass;
    always #5 clk_sys = ~clk_sys;
    flash_copy_erase_sequencer DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reqCopy(reqCopy),
        .reqErase(reqErase), .paramBlockBase(paramBlockBase), .intMaskIn(intMaskIn),
        .busy(busy), .done(done), .eraseRefused(eraseRefused), .ramRd(ramRd), .ramWr(ramWr),
        .ramAddr(ramAddr), .ramWrData(ramWrData), .ramRdData(ramRdData), .flashRd(flashRd),
        .flashAddr(flashAddr), .flashRdData(flashRdData), .erasePage(erasePage),
        .eraseMass(eraseMass), .eraseAddr(eraseAddr), .protectHit(protectHit),
        .testHighVoltage(testHighVoltage), .intMaskOut(intMaskOut),
        .watchdogService(watchdogService));
    fces_sw_model mdl (.clk(clk_sys), .ramRd(ramRd), .ramWr(ramWr), .ramAddr(ramAddr),
        .ramWrData(ramWrData), .ramRdData(ramRdData), .flashRd(flashRd),
        .flashAddr(flashAddr), .flashRdData(flashRdData), .eraseAddr(eraseAddr),
        .protectHit(protectHit));
    task finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_mismatch++;
            finish_test();
        end
    end
    // parameter block as software leaves it
    task fill(input [15:0] b, input [7:0] s, input [7:0] c, input [15:0] a);
        mdl.ram[b] = s;
        mdl.ram[b + 16'h0001] = c;
        mdl.ram[b + 16'h0002] = a[15:8];
        mdl.ram[b + 16'h0003] = a[7:0];
    endtask
    // one request, cycles counted from the taking edge
    task run(input bit cp, input [15:0] b, input bit im);
        int n;
        n = -1;
        tWd = 0;
        nPage = 0;
        nMass = 0;
        @(posedge clk_sys);
        paramBlockBase <= b;
        intMaskIn <= im;
        reqCopy <= cp;
        reqErase <= !cp;
        do
        begin
            @(posedge clk_sys);
            reqCopy <= 1'b0;
            reqErase <= cp && n == 3;
            #1;
            n++;
            if (watchdogService && tWd == 0)
                tWd = n;
            if (erasePage)
                ea = eraseAddr;
            nPage += erasePage;
            nMass += eraseMass;
        end while (done !== 1'b1 && n < 40000);
        `CHK(done, 1'b1)
        @(posedge clk_sys);
        #1;
    endtask
    // copy across a page edge, erase request while busy
    task t_copy;
        fill(16'h0100, 8'h00, 8'h03, 16'hFF3E);
        mdl.ram[16'h0107] = 8'h5A;
        run(1'b1, 16'h0100, 1'b0);
        for (int i = 0; i < 3; i++)
            `CHK(mdl.ram[16'h0104 + i], 8'h3E + i[7:0] ^ 8'hFF)
        `CHK(mdl.ram[16'h0107], 8'h5A)
        `CHK(nPage + nMass, 0)
        `CHK(tWd, 0)
        `CHK(intMaskOut, 1'b0)
    endtask
    task t_erase(input [7:0] s, input [15:0] a, input bit tv, input bit im, input bit pg,
                 input bit ms);
        fill(16'h0090, s, 8'h00, a);
        @(posedge clk_sys);
        testHighVoltage <= tv;
        run(1'b0, 16'h0090, im);
        `CHK(nPage, pg ? 16 + 1100 * s + 1 : 0)
        `CHK(nMass, ms ? 16 + 1100 * s + 1 : 0)
        `CHK(tWd, (pg | ms) ? 72 + 3 * s : 0)
        `CHK(eraseRefused, !(pg | ms))
        `CHK(intMaskOut, im)
        if (pg)
            `CHK(ea, a & 16'hFFC0)
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_copy();
        t_erase(8'h06, 16'hE121, 1'b0, 1'b0, 1'b1, 1'b0);
        t_erase(8'h20, 16'hFFFE, 1'b1, 1'b1, 1'b0, 1'b1);
        t_erase(8'h08, 16'hFFFE, 1'b0, 1'b0, 1'b0, 1'b0);
        t_erase(8'h0C, 16'hF040, 1'b0, 1'b0, 1'b0, 1'b0);
        t_erase(8'h0C, 16'hF07F, 1'b1, 1'b0, 1'b1, 1'b0);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
